// ===== typec_port_defines.vh
// Constants for the Type-C port mode control block
`ifndef TYPEC_PORT_DEFINES_VH
`define TYPEC_PORT_DEFINES_VH

// ***************************************************************
// Clock and timing
// ***************************************************************
`define CLK_PERIOD_PS     5000
`define CC_DEB_NS         10000
`define CC_DEB_CYC        ((`CC_DEB_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DRP_TOGGLE_NS     50000
`define DRP_TOGGLE_CYC    ((`DRP_TOGGLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DEB_CNT_W         12
`define TOG_CNT_W         16

// ***************************************************************
// Role configuration codes
// ***************************************************************
`define ROLE_DRP          2'h0
`define ROLE_SNK          2'h1
`define ROLE_SRC          2'h2

// ***************************************************************
// Current level codes
// ***************************************************************
`define LVL_NONE          2'h0
`define LVL_DEF           2'h1
`define LVL_MED           2'h2
`define LVL_HIGH          2'h3
`define ADV_DEF           2'h0
`define ADV_MED           2'h1
`define ADV_HIGH          2'h2

// ***************************************************************
// Functional mode codes
// ***************************************************************
`define PMODE_UNATT       2'h0
`define PMODE_ACTIVE      2'h1
`define PMODE_SHUTDOWN    2'h2
`define PMODE_DEADBAT     2'h3

// ***************************************************************
// Filtered input vector layout
// ***************************************************************
`define FV_W              13
`define FV_RST            13'h0100
`define FV_BUS_HI         12
`define FV_BUS_LO         11
`define FV_SHUT           8
`define FV_SUPPLY         9
`define FV_VBUS           10

`endif

// ===== sync_filter.v
// Two-stage synchroniser followed by a stability filter
`timescale 1ns/1ps

module sync_filter #(
  parameter          W   = 8,
  parameter          CW  = 12,
  parameter [W-1:0]  RST = {W{1'b0}},
  parameter [CW-1:0] CNT = 12'h001
) (
  input  wire          i_mclk,    // System clock
  input  wire          i_rst,     // Synchronous reset, active high
  input  wire [W-1:0]  i_async,   // Asynchronous inputs
  output wire [W-1:0]  o_stable   // Filtered, synchronous inputs
);

  reg [W-1:0]  meta_r;
  reg [W-1:0]  sync_r;
  reg [W-1:0]  stable_r;
  reg [CW-1:0] cnt_r;

  // ***************************************************************
  // Synchroniser and filter
  // ***************************************************************
  always @(posedge i_mclk) begin
    if (i_rst) begin
      meta_r   <= RST;
      sync_r   <= RST;
      stable_r <= RST;
      cnt_r    <= {CW{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
      if (sync_r == stable_r) begin
        cnt_r <= {CW{1'b0}};
      end else if (cnt_r >= CNT - 1'b1) begin
        stable_r <= sync_r;
        cnt_r    <= {CW{1'b0}};
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign o_stable = stable_r;

endmodule // sync_filter

// ===== typec_port_mode_control.v
// Type-C port mode control: state tracking, open-drain outputs, VCONN gating
//
// Operation
// - Floating bus select pin means GPIO mode, driven high or low means I2C mode.
// - Every status pin is open drain: it only pulls low or releases.
// - GPIO mode shows current level on two pins, unattached or attached.
// - GPIO mode pulls audio pin low while an audio accessory is attached.
// - I2C mode pulls alert low when status information changes.
// - Alert pending flag set with alert; host clears it by a write.
// - VBUS sense drives sink attach and detach, and debug accessory entry/exit on the sink side.
// - Orientation pin low for CC1, released high for CC2.
// - Detected orientation is also given as a status output.
// - VCONN onto the open CC pin only in Attached.SRC with Ra there.
// - VCONN is removed on detach and cable removal.
// - Unattached states per role; dual role toggles sink and source.
// - Attached states per role; debug accessory in every role, audio accessory in source and dual role only.
// - Start in Unattached.SNK after power-up; sink role stays there until attach, dual role toggles.
// - Source attach on sink-present pin; in GPIO mode sink attach on level pins and audio accessory on audio pin.
// - Leave active on unplug, VBUS loss as sink, supply loss or shutdown.
// - Shutdown powers logic down but keeps Rd on both CC pins.
// - Without supply the CC pins default to Rd terminations.
// - GPIO mode advertises only default current as source.
// - Dual role alternates Rp on both pins and Rd on both pins.
`timescale 1ns/1ps
`include "typec_port_defines.vh"

module typec_port_mode_control #(
  parameter [`TOG_CNT_W-1:0] TOGGLE_CYC = `DRP_TOGGLE_CYC
) (
  input  wire       i_mclk,                 // System clock, 200 MHz
  input  wire       i_rst,                  // Synchronous reset, active high
  input  wire       i_bus_sel_hi,           // Bus select pin sensed driven high
  input  wire       i_bus_sel_lo,           // Bus select pin sensed driven low
  input  wire       i_shutdown_req,         // Shutdown request, high or floating
  input  wire       i_supply_ok,            // Supply present
  input  wire       i_supply_sense_in,      // VBUS present
  input  wire [1:0] i_cc1_rp,               // Rp level seen on CC1 as sink
  input  wire [1:0] i_cc2_rp,               // Rp level seen on CC2 as sink
  input  wire       i_cc1_rd,               // Rd seen on CC1 as source
  input  wire       i_cc2_rd,               // Rd seen on CC2 as source
  input  wire       i_cc1_ra,               // Ra seen on CC1 as source
  input  wire       i_cc2_ra,               // Ra seen on CC2 as source
  input  wire [1:0] i_role_mode,            // Role configuration in I2C mode
  input  wire [1:0] i_adv_level,            // Source advertisement in I2C mode
  input  wire       i_alert_clear,          // Host write clearing alert, pulse
  output reg        o_current_level_out_a,  // Level pin a pull-down enable
  output reg        o_current_level_out_b,  // Level pin b pull-down enable
  output reg        o_audio_attach_out,     // Audio / alert pin pull-down enable
  output reg        o_orient_oe,            // Orientation pin pull-down enable
  output reg        o_sink_present_out,     // Sink-present pin pull-down enable
  output reg        o_vconn_cc1_en,         // VCONN switch onto CC1
  output reg        o_vconn_cc2_en,         // VCONN switch onto CC2
  output reg        o_term_rp_en,           // Rp on both CC pins
  output reg        o_term_rd_en,           // Rd on both CC pins
  output reg  [1:0] o_rp_adv,               // Rp advertisement level
  output reg        o_gpio_mode,            // GPIO output mode active
  output reg  [1:0] o_port_mode,            // Functional mode
  output reg  [2:0] o_tc_state,             // Type-C state code
  output reg        o_orient_cc2,           // Attached on CC2
  output reg  [1:0] o_cur_detect,           // Detected current as sink
  output reg        o_alert_pending         // Alert pending flag
);

  // ***************************************************************
  // State codes
  // ***************************************************************
  localparam [2:0] S_UNATT_SNK = 3'h0;
  localparam [2:0] S_ATTW_SNK  = 3'h1;
  localparam [2:0] S_UNATT_SRC = 3'h2;
  localparam [2:0] S_ATTW_SRC  = 3'h3;
  localparam [2:0] S_ATT_SNK   = 3'h4;
  localparam [2:0] S_ATT_SRC   = 3'h5;
  localparam [2:0] S_AUDIO     = 3'h6;
  localparam [2:0] S_DEBUG     = 3'h7;

  localparam integer          DEB_CYC_I = `CC_DEB_CYC;
  localparam [`DEB_CNT_W-1:0] DEB_CYC   = DEB_CYC_I[`DEB_CNT_W-1:0];

  function one_of;
    input a;
    input b;
    begin
      one_of = a ^ b;
    end
  endfunction

  // ***************************************************************
  // Input synchronisation and debounce
  // ***************************************************************
  wire [`FV_W-1:0] fv;

  sync_filter #(
    .W   (`FV_W),
    .CW  (`DEB_CNT_W),
    .RST (`FV_RST),
    .CNT (DEB_CYC)
  ) u_filter (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_async  ({i_bus_sel_hi, i_bus_sel_lo, i_supply_sense_in, i_supply_ok,
                i_shutdown_req, i_cc1_rp, i_cc2_rp, i_cc1_rd, i_cc2_rd,
                i_cc1_ra, i_cc2_ra}),
    .o_stable (fv)
  );

  wire       vbus   = fv[`FV_VBUS];
  wire       supply = fv[`FV_SUPPLY];
  wire       shut   = fv[`FV_SHUT];
  wire [1:0] rp1    = fv[7:6];
  wire [1:0] rp2    = fv[5:4];
  wire       rd1    = fv[3];
  wire       rd2    = fv[2];
  wire       ra1    = fv[1];
  wire       ra2    = fv[0];

  wire gpio_mode = ~fv[`FV_BUS_HI] & ~fv[`FV_BUS_LO];
  wire i2c_mode  = ~gpio_mode;

  // Sink-only and source-only need I2C; GPIO mode is always dual role
  wire [1:0] role  = gpio_mode ? `ROLE_DRP : i_role_mode;
  wire       r_drp = (role != `ROLE_SNK) && (role != `ROLE_SRC);
  wire       r_snk = (role == `ROLE_SNK);
  wire       r_src = (role == `ROLE_SRC);

  // supply loss or shutdown leaves active mode
  wire powered = supply & ~shut;

  wire rp1_seen = |rp1;
  wire rp2_seen = |rp2;

  // ***************************************************************
  // State registers
  // ***************************************************************
  reg [2:0]            state_r;
  reg [2:0]            state_nxt;
  reg                  orient_r;
  reg                  orient_nxt;
  reg                  dbg_src_r;
  reg                  dbg_src_nxt;
  reg [`TOG_CNT_W-1:0] tog_r;
  reg [`TOG_CNT_W-1:0] tog_nxt;
  reg [1:0]            det_lvl_r;
  reg [1:0]            det_lvl_nxt;
  reg [7:0]            snap_r;

  wire tog_done = (tog_r >= TOGGLE_CYC - 1'b1);
  wire unatt_home_src = r_src;

  // ***************************************************************
  // Type-C state machine
  // ***************************************************************
  always @* begin
    state_nxt   = state_r;
    orient_nxt  = orient_r;
    dbg_src_nxt = dbg_src_r;
    tog_nxt     = {`TOG_CNT_W{1'b0}};
    det_lvl_nxt = det_lvl_r;
    case (state_r)
      S_UNATT_SNK: begin
        det_lvl_nxt = `LVL_NONE;
        if (r_src) begin
          state_nxt = S_UNATT_SRC;
        end else if (rp1_seen | rp2_seen) begin
          state_nxt = S_ATTW_SNK;
        end else if (r_drp) begin
          if (tog_done) begin
            state_nxt = S_UNATT_SRC;
          end else begin
            tog_nxt = tog_r + 1'b1;
          end
        end
      end
      S_ATTW_SNK: begin
        if (~rp1_seen & ~rp2_seen) begin
          state_nxt = unatt_home_src ? S_UNATT_SRC : S_UNATT_SNK;
        end else if (vbus & rp1_seen & rp2_seen) begin
          state_nxt   = S_DEBUG;
          dbg_src_nxt = 1'b0;
        end else if (vbus) begin
          state_nxt   = S_ATT_SNK;
          orient_nxt  = rp2_seen;
          det_lvl_nxt = rp2_seen ? rp2 : rp1;
        end
      end
      S_UNATT_SRC: begin
        if (r_snk) begin
          state_nxt = S_UNATT_SNK;
        end else if (rd1 | rd2 | (ra1 & ra2)) begin
          state_nxt = S_ATTW_SRC;
        end else if (r_drp) begin
          if (tog_done) begin
            state_nxt = S_UNATT_SNK;
          end else begin
            tog_nxt = tog_r + 1'b1;
          end
        end
      end
      S_ATTW_SRC: begin
        if (rd1 & rd2) begin
          state_nxt   = S_DEBUG;
          dbg_src_nxt = 1'b1;
        end else if (one_of(rd1, rd2)) begin
          state_nxt  = S_ATT_SRC;
          orient_nxt = rd2;
        end else if (ra1 & ra2) begin
          state_nxt = S_AUDIO;
        end else begin
          state_nxt = unatt_home_src ? S_UNATT_SRC : S_UNATT_SNK;
        end
      end
      S_ATT_SNK: begin
        det_lvl_nxt = orient_r ? rp2 : rp1;
        if (~vbus) begin
          state_nxt = unatt_home_src ? S_UNATT_SRC : S_UNATT_SNK;
        end
      end
      S_ATT_SRC: begin
        if (~(orient_r ? rd2 : rd1)) begin
          state_nxt = unatt_home_src ? S_UNATT_SRC : S_UNATT_SNK;
        end
      end
      S_AUDIO: begin
        if (~(ra1 & ra2)) begin
          state_nxt = unatt_home_src ? S_UNATT_SRC : S_UNATT_SNK;
        end
      end
      default: begin
        if (dbg_src_r ? ~(rd1 & rd2) : ~(vbus & rp1_seen & rp2_seen)) begin
          state_nxt = unatt_home_src ? S_UNATT_SRC : S_UNATT_SNK;
        end
      end
    endcase
    // forced back to sink without power
    if (~powered) begin
      state_nxt   = S_UNATT_SNK;
      det_lvl_nxt = `LVL_NONE;
      tog_nxt     = {`TOG_CNT_W{1'b0}};
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      state_r   <= S_UNATT_SNK;
      orient_r  <= 1'b0;
      dbg_src_r <= 1'b0;
      tog_r     <= {`TOG_CNT_W{1'b0}};
      det_lvl_r <= `LVL_NONE;
    end else begin
      state_r   <= state_nxt;
      orient_r  <= orient_nxt;
      dbg_src_r <= dbg_src_nxt;
      tog_r     <= tog_nxt;
      det_lvl_r <= det_lvl_nxt;
    end
  end

  // ***************************************************************
  // Derived status
  // ***************************************************************
  wire attached = state_nxt[2];
  wire src_side = (state_nxt == S_UNATT_SRC) || (state_nxt == S_ATTW_SRC) ||
                  (state_nxt == S_ATT_SRC) || (state_nxt == S_AUDIO) ||
                  ((state_nxt == S_DEBUG) & dbg_src_nxt);

  wire vconn1 = (state_nxt == S_ATT_SRC) & orient_nxt & ra1;
  wire vconn2 = (state_nxt == S_ATT_SRC) & ~orient_nxt & ra2;

  reg       lvl_a;
  reg       lvl_b;
  reg [1:0] adv;

  always @* begin
    lvl_a = 1'b0;
    lvl_b = 1'b0;
    if (state_nxt == S_ATT_SNK) begin
      case (det_lvl_nxt)
        `LVL_MED:  lvl_a = 1'b1;
        `LVL_HIGH: begin
          lvl_a = 1'b1;
          lvl_b = 1'b1;
        end
        default:   lvl_b = 1'b1;
      endcase
    end else if (attached) begin
      lvl_b = 1'b1;
    end
  end

  always @* begin
    adv = `ADV_DEF;
    if (i2c_mode && (i_adv_level != 2'h3)) begin
      adv = i_adv_level;
    end
  end

  wire [7:0] snap_now = {state_nxt, orient_nxt & attached, det_lvl_nxt,
                         vconn1, vconn2};
  wire       alert_set = i2c_mode & powered & (snap_now != snap_r);

  // ***************************************************************
  // Output registers
  // ***************************************************************
  always @(posedge i_mclk) begin
    if (i_rst) begin
      snap_r                <= 8'h00;
      o_current_level_out_a <= 1'b0;
      o_current_level_out_b <= 1'b0;
      o_audio_attach_out    <= 1'b0;
      o_orient_oe           <= 1'b0;
      o_sink_present_out    <= 1'b0;
      o_vconn_cc1_en        <= 1'b0;
      o_vconn_cc2_en        <= 1'b0;
      o_term_rp_en          <= 1'b0;
      o_term_rd_en          <= 1'b1;
      o_rp_adv              <= `ADV_DEF;
      o_gpio_mode           <= 1'b1;
      o_port_mode           <= `PMODE_DEADBAT;
      o_tc_state            <= S_UNATT_SNK;
      o_orient_cc2          <= 1'b0;
      o_cur_detect          <= `LVL_NONE;
      o_alert_pending       <= 1'b0;
    end else begin
      snap_r      <= snap_now;
      o_gpio_mode <= gpio_mode;
      o_tc_state  <= state_nxt;
      // pins only pull low when powered
      o_current_level_out_a <= powered & gpio_mode & lvl_a;
      o_current_level_out_b <= powered & gpio_mode & lvl_b;
      // audio in GPIO mode, alert in I2C mode
      o_audio_attach_out <= powered & (gpio_mode ? (state_nxt == S_AUDIO)
                                                 : (o_alert_pending | alert_set));
      o_alert_pending <= alert_set | (o_alert_pending & ~i_alert_clear);
      o_orient_oe  <= powered & attached & ~orient_nxt;
      o_orient_cc2 <= attached & orient_nxt;
      o_sink_present_out <= powered & (state_nxt == S_ATT_SRC);
      o_vconn_cc1_en <= powered & vconn1;
      o_vconn_cc2_en <= powered & vconn2;
      // Rp on both pins on the source side
      o_term_rp_en <= powered & src_side;
      o_term_rd_en <= ~(powered & src_side);
      o_rp_adv     <= adv;
      o_cur_detect <= det_lvl_nxt;
      if (~supply) begin
        o_port_mode <= `PMODE_DEADBAT;
      end else if (shut) begin
        o_port_mode <= `PMODE_SHUTDOWN;
      end else if (attached) begin
        o_port_mode <= `PMODE_ACTIVE;
      end else begin
        o_port_mode <= `PMODE_UNATT;
      end
    end
  end

endmodule // typec_port_mode_control

// ===== cc_partner.sv
// Port partner model: source, sink with optional active cable, audio adapter
`timescale 1ns/1ps

module cc_partner (
  input  wire       i_term_rd_en,  // Device presents Rd
  input  wire [1:0] i_kind,        // 0 none, 1 source, 2 sink, 3 audio
  input  wire [1:0] i_level,       // Rp level shown as source
  input  wire       i_flip,        // Plugged onto CC2
  input  wire       i_cable,       // Active cable Ra on the open pin
  input  wire       i_no_vbus,     // Source withholds VBUS
  output wire [1:0] o_cc1_rp,      // Rp level on CC1
  output wire [1:0] o_cc2_rp,      // Rp level on CC2
  output wire       o_cc1_rd,      // Rd on CC1
  output wire       o_cc2_rd,      // Rd on CC2
  output wire       o_cc1_ra,      // Ra on CC1
  output wire       o_cc2_ra,      // Ra on CC2
  output wire       o_vbus         // VBUS present
);
  wire src = (i_kind == 2'h1);
  wire snk = (i_kind == 2'h2);
  wire aud = (i_kind == 2'h3);
  assign o_cc1_rp = (src && !i_flip) ? i_level : 2'h0;
  assign o_cc2_rp = (src && i_flip) ? i_level : 2'h0;
  assign o_cc1_rd = snk && !i_flip;
  assign o_cc2_rd = snk && i_flip;
  assign o_cc1_ra = aud || (snk && i_flip && i_cable);
  assign o_cc2_ra = aud || (snk && !i_flip && i_cable);
  // VBUS after Rd
  // A source only powers VBUS while it sees the device's Rd
  assign o_vbus = src && !i_no_vbus && i_term_rd_en;
endmodule // cc_partner

// ===== typec_port_checker_properties.sv
// Concurrent checks on the port mode control block's ports
`timescale 1ns/1ps

module typec_port_checker (
  input  wire       i_mclk,                 // System clock
  input  wire       i_rst,                  // Synchronous reset
  input  wire       i_supply_sense_in,      // VBUS present
  input  wire       o_current_level_out_a,  // Level pin a pull
  input  wire       o_current_level_out_b,  // Level pin b pull
  input  wire       o_audio_attach_out,     // Audio / alert pull
  input  wire       o_orient_oe,            // Orientation pull
  input  wire       o_sink_present_out,     // Sink-present pull
  input  wire       o_vconn_cc1_en,         // VCONN onto CC1
  input  wire       o_vconn_cc2_en,         // VCONN onto CC2
  input  wire       o_term_rp_en,           // Rp on
  input  wire       o_term_rd_en,           // Rd on
  input  wire [1:0] o_rp_adv,               // Advertisement
  input  wire       o_gpio_mode,            // GPIO mode
  input  wire [1:0] o_port_mode,            // Functional mode
  input  wire [2:0] o_tc_state,             // Type-C state
  input  wire       o_orient_cc2,           // Attached on CC2
  input  wire       o_alert_pending         // Alert flag
);
  localparam int VBUS_WAIT = 2100;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  reg [11:0] vbus_lost_cnt;

  // Cycles spent in Attached.SNK with VBUS gone
  always @(posedge i_mclk) begin
    if (i_rst || (o_tc_state != 3'h4) || i_supply_sense_in) begin
      vbus_lost_cnt <= 12'h000;
    end else if (vbus_lost_cnt != 12'hfff) begin
      vbus_lost_cnt <= vbus_lost_cnt + 12'h001;
    end
  end

  a_vconn_cc1_src: assert property (o_vconn_cc1_en |-> o_tc_state == 3'h5 && o_orient_cc2)
    else $error("vconn cc1 outside source attach");
  a_vconn_cc2_src: assert property (o_vconn_cc2_en |-> o_tc_state == 3'h5 && !o_orient_cc2)
    else $error("vconn cc2 outside source attach");
  a_vconn_drop: assert property ($past(o_tc_state) == 3'h5 && o_tc_state != 3'h5 |->
    !o_vconn_cc1_en && !o_vconn_cc2_en) else $error("vconn kept after detach");
  a_sink_present: assert property (o_sink_present_out == (o_tc_state == 3'h5))
    else $error("sink present pin mismatch");
  a_orient_pin: assert property (o_orient_oe |-> !o_orient_cc2)
    else $error("orientation pin low while on cc2");
  a_level_unatt: assert property (o_tc_state < 3'h4 |-> !o_current_level_out_a &&
    !o_current_level_out_b) else $error("level pins pulled while unattached");
  a_level_bus: assert property (!o_gpio_mode |-> !o_current_level_out_a &&
    !o_current_level_out_b) else $error("level pins pulled in bus mode");
  a_adv_gpio: assert property (o_gpio_mode |-> o_rp_adv == 2'h0)
    else $error("advertisement above default in gpio mode");
  a_rd_unpowered: assert property (o_port_mode[1] |-> o_term_rd_en && !o_term_rp_en)
    else $error("Rd missing while unpowered");
  a_alert_gpio: assert property (o_gpio_mode && $past(o_gpio_mode) |-> !$rose(o_alert_pending))
    else $error("alert raised in gpio mode");
  a_audio_gpio: assert property (o_gpio_mode && $past(o_gpio_mode) |->
    o_audio_attach_out == (o_tc_state == 3'h6)) else $error("audio pin mismatch");
  a_sink_vbus: assert property (vbus_lost_cnt < VBUS_WAIT)
    else $error("sink attach kept after vbus loss");
endmodule // typec_port_checker

// ===== test_typec_port_mode_control.sv
// Scenario testbench for the Type-C port mode control block
`timescale 1ns/1ps
`include "typec_port_defines.vh"

module test_typec_port_mode_control;
  reg        i_mclk = 1'b0;
  reg        i_rst = 1'b1;
  reg        sel_hi = 1'b0;
  reg        sel_lo = 1'b0;
  reg        shut = 1'b0;
  reg        supply = 1'b1;
  reg  [1:0] role = `ROLE_DRP;
  reg  [1:0] adv = `ADV_DEF;
  reg        clr = 1'b0;
  reg  [1:0] kind = 2'h0;
  reg  [1:0] lvl = 2'h0;
  reg        flip = 1'b0;
  reg        cable = 1'b0;
  reg        no_vbus = 1'b0;
  wire [1:0] cc1_rp, cc2_rp, rp_adv, port_mode, cur_det;
  wire [2:0] tc;
  wire       cc1_rd, cc2_rd, cc1_ra, cc2_ra, vbus, pa, pb, aud, ori, sp, v1, v2;
  wire       rp_en, rd_en, gpio, ori2, alert;
  integer    n_errors = 0;
  integer    checks = 0;
  integer    cycles = 0;
  integer    l;

  initial forever #2.5 i_mclk = ~i_mclk;

  typec_port_mode_control #(.TOGGLE_CYC(16)) u_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_bus_sel_hi(sel_hi), .i_bus_sel_lo(sel_lo),
    .i_shutdown_req(shut), .i_supply_ok(supply), .i_supply_sense_in(vbus),
    .i_cc1_rp(cc1_rp), .i_cc2_rp(cc2_rp), .i_cc1_rd(cc1_rd), .i_cc2_rd(cc2_rd),
    .i_cc1_ra(cc1_ra), .i_cc2_ra(cc2_ra), .i_role_mode(role), .i_adv_level(adv),
    .i_alert_clear(clr), .o_current_level_out_a(pa), .o_current_level_out_b(pb),
    .o_audio_attach_out(aud), .o_orient_oe(ori), .o_sink_present_out(sp),
    .o_vconn_cc1_en(v1), .o_vconn_cc2_en(v2), .o_term_rp_en(rp_en), .o_term_rd_en(rd_en),
    .o_rp_adv(rp_adv), .o_gpio_mode(gpio), .o_port_mode(port_mode), .o_tc_state(tc),
    .o_orient_cc2(ori2), .o_cur_detect(cur_det), .o_alert_pending(alert));

  cc_partner u_partner (
    .i_term_rd_en(rd_en), .i_kind(kind), .i_level(lvl), .i_flip(flip), .i_cable(cable),
    .i_no_vbus(no_vbus), .o_cc1_rp(cc1_rp), .o_cc2_rp(cc2_rp), .o_cc1_rd(cc1_rd),
    .o_cc2_rd(cc2_rd), .o_cc1_ra(cc1_ra), .o_cc2_ra(cc2_ra), .o_vbus(vbus));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task check(input [8*16-1:0] name, input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  // Debounce length is fixed, so each input change settles in a known time
  task settle(input integer k);
    repeat (k * (`CC_DEB_CYC + 40)) @(negedge i_mclk);
  endtask

  task report_and_stop;
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task t_unatt(input src_exp);
    reg seen_src;
    begin
      seen_src = 1'b0;
      repeat (60) begin
        @(negedge i_mclk);
        if (tc === 3'h2) begin
          seen_src = 1'b1;
          check("term_src", {rp_en, rd_en}, 8'h02);
        end
      end
      check("toggle", seen_src, src_exp);
    end
  endtask

  task t_sink(input [1:0] level, input on_cc2);
    begin
      kind = 2'h1;
      lvl = level;
      flip = on_cc2;
      settle(2);
      check("snk_state", tc, 8'h04);
      check("snk_mode", port_mode, `PMODE_ACTIVE);
      check("cur_det", cur_det, level);
      check("level_pins", {pa, pb}, (level == `LVL_DEF) ? 8'h01 : (level == `LVL_MED) ? 8'h02 : 8'h03);
      check("orient", {ori, ori2}, on_cc2 ? 8'h01 : 8'h02);
      no_vbus = 1'b1;
      settle(1);
      check("vbus_loss", tc, 8'h01);
      check("pins_loss", {pa, pb}, 8'h00);
      kind = 2'h0;
      no_vbus = 1'b0;
      settle(1);
    end
  endtask

  task t_source(input on_cc2);
    begin
      kind = 2'h2;
      flip = on_cc2;
      cable = 1'b1;
      settle(1);
      check("src_state", tc, 8'h05);
      check("sink_present", sp, 8'h01);
      check("src_orient", {ori, ori2}, on_cc2 ? 8'h01 : 8'h02);
      check("vconn", {v1, v2}, on_cc2 ? 8'h02 : 8'h01);
      check("alert_pin", {alert, aud}, 8'h03);
      @(negedge i_mclk);
      clr = 1'b1;
      @(negedge i_mclk);
      clr = 1'b0;
      check("alert_clear", alert, 8'h00);
      kind = 2'h0;
      settle(1);
      check("vconn_off", {v1, v2, sp}, 8'h00);
      check("src_home", tc, 8'h02);
    end
  endtask

  initial begin
    repeat (8) @(negedge i_mclk);
    i_rst = 1'b0;
    check("rst_state", {tc, rd_en, rp_en, v1, v2}, 8'h08);
    settle(1);
    check("gpio", gpio, 8'h01);
    check("unatt", {port_mode, tc}, 8'h00);
    t_unatt(1'b1);
    for (l = 1; l < 4; l = l + 1)
      t_sink(l[1:0], l == 2);
    // Advertisement request ignored in GPIO mode
    adv = `ADV_HIGH;
    kind = 2'h3;
    settle(1);
    check("audio", {tc, aud}, 8'h0d);
    check("adv_gpio", rp_adv, `ADV_DEF);
    kind = 2'h0;
    shut = 1'b1;
    settle(1);
    check("shutdown", {port_mode, tc, rd_en, rp_en}, 8'h42);
    shut = 1'b0;
    supply = 1'b0;
    settle(1);
    check("deadbat", {port_mode, tc, rd_en, rp_en}, 8'h62);
    supply = 1'b1;
    sel_lo = 1'b1;
    role = `ROLE_SNK;
    settle(1);
    check("bus_mode", {gpio, port_mode}, 8'h00);
    t_unatt(1'b0);
    sel_lo = 1'b0;
    sel_hi = 1'b1;
    role = `ROLE_SRC;
    settle(1);
    check("bus_hi", gpio, 8'h00);
    check("adv_bus", rp_adv, `ADV_HIGH);
    t_source(1'b0);
    t_source(1'b1);
    report_and_stop;
  end
endmodule // test_typec_port_mode_control

bind typec_port_mode_control typec_port_checker u_chk (
  .i_mclk, .i_rst, .i_supply_sense_in, .o_current_level_out_a, .o_current_level_out_b,
  .o_audio_attach_out, .o_orient_oe, .o_sink_present_out, .o_vconn_cc1_en, .o_vconn_cc2_en,
  .o_term_rp_en, .o_term_rd_en, .o_rp_adv, .o_gpio_mode, .o_port_mode, .o_tc_state,
  .o_orient_cc2, .o_alert_pending);
